// *** rtl/ict_core.sv ***
// instruction cycle timing core with fetch, sequencing and alu
// What this block does
// [RULE_01] one instruction cycle is four clocks
// [RULE_02] ordinary instructions finish in one cycle
// [RULE_03] jump, call, returns, table read take two
// [RULE_04] writing program counter low byte jumps, extra cycle
// [RULE_05] taken skip costs one extra cycle
// [RULE_06] add carry above 255, subtract borrow below zero
// [RULE_07] increment and decrement change by one
// [RULE_08] logic ops set zero flag from result
// [RULE_09] rotates move one bit, carry forms via carry
// [RULE_10] three move forms to and from accumulator
// [RULE_11] logic operands pass through the accumulator; CPL and CPLA take only the memory operand
// [RULE_12] add/sub set four flags, adjust only carry
// [RULE_13] flow change discards prefetch, dummy fetch follows
`default_nettype none
module ict_core (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst,
    input  wire logic [ict_pkg::WORD_W-1:0]  i_instr,
    output var  logic [ict_pkg::ADDR_W-1:0]  o_pm_addr,
    output var  logic [7:0]                  o_acc,
    output var  logic                        o_zero,
    output var  logic                        o_carry,
    output var  logic                        o_aux_carry,
    output var  logic                        o_overflow,
    output var  logic                        o_int_en,
    output var  logic [6:0]                  o_table_high,
    output var  logic                        o_icycle,
    output var  logic                        o_executed
);
    import ict_pkg::*;

    logic [1:0]              phase;
    ict_state_t              st;
    logic [WORD_W-1:0]       ir;
    logic [ADDR_W-1:0]       ir_addr;
    logic [ADDR_W-1:0]       pc_save;
    logic [DM_AW-1:0]        tab_dst;
    logic [7:0]              dm [DM_DEPTH];
    logic [ADDR_W-1:0]       stk [STK_DEPTH];
    logic [SP_W-1:0]         sp;

    logic                    ex;
    logic                    is_br;
    ict_op_t                 op;
    logic [DM_AW-1:0]        maddr;
    logic [7:0]              opnd;
    logic [7:0]              imm;
    logic [7:0]              next_res;
    logic                    next_z, next_c, next_ac, next_ov;
    logic                    wr_acc, wr_mem, jump, skip, table_rd;
    logic                    push, pop, set_ie;
    logic [ADDR_W-1:0]       target;
    logic [10:0]             as;
    logic [8:0]              dadj;
    logic                    dlo, dhi;

    // returns {ov, ac, c, result}; for sub, cin and c mean borrow
    function automatic logic [10:0] ict_addsub(input logic [7:0] a,
        input logic [7:0] b, input logic cin, input logic sub);
        logic [7:0] bb;
        logic       ci;
        logic [8:0] s;
        logic [4:0] h;
        bb = sub ? ~b : b;
        ci = sub ? ~cin : cin;
        s  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        h  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        return {(a[7] == bb[7]) && (s[7] != a[7]), h[4] ^ sub,
                s[8] ^ sub, s[7:0]};
    endfunction : ict_addsub

    assign ex    = (st == ST_RUN) && (phase == PH_LAST);
    assign is_br = (ir[BR_HI:BR_LO] == BR_PFX);
    assign op    = ict_op_t'(ir[OPC_HI:OPC_LO]);
    assign maddr = ir[DM_AW-1:0];
    assign imm   = ir[7:0];
    // reading the low program counter byte sees the current address
    assign opnd  = (maddr == DM_PCL) ? ir_addr[7:0] : dm[maddr];

    always_comb begin
        as = 11'h000;
        unique case (op)
            OP_ADDM: as = ict_addsub(o_acc, opnd, 1'b0, 1'b0);
            OP_ADDX: as = ict_addsub(o_acc, imm, 1'b0, 1'b0);
            OP_ADCM: as = ict_addsub(o_acc, opnd, o_carry, 1'b0);
            OP_SUBM: as = ict_addsub(o_acc, opnd, 1'b0, 1'b1);
            OP_SUBX: as = ict_addsub(o_acc, imm, 1'b0, 1'b1);
            OP_SBCM: as = ict_addsub(o_acc, opnd, o_carry, 1'b1);
            default: as = 11'h000;
        endcase
        dlo  = (o_acc[3:0] > BCD_NINE) || o_aux_carry;
        dadj = {1'b0, o_acc} + (dlo ? BCD_ADJ_LO : 9'h000);
        dhi  = (dadj[7:4] > BCD_NINE) || dadj[8] || o_carry;
        dadj = dadj + (dhi ? BCD_ADJ_HI : 9'h000);
    end

    always_comb begin
        next_res = 8'h00;
        next_z   = o_zero;
        next_c   = o_carry;
        next_ac  = o_aux_carry;
        next_ov  = o_overflow;
        wr_acc   = 1'b0;
        wr_mem   = 1'b0;
        jump     = 1'b0;
        skip     = 1'b0;
        table_rd = 1'b0;
        push     = 1'b0;
        pop      = 1'b0;
        set_ie   = 1'b0;
        target   = ir[ADDR_W-1:0];
        if (is_br) begin
            // [RULE_03] jump and call
            jump = 1'b1;
            push = ir[BR_CALL_BIT];
        end else begin
            unique case (op)
                OP_NOP: ;
                // [RULE_10] three move forms
                OP_MOVAM: begin next_res = opnd;  wr_acc = 1'b1; end
                OP_MOVMA: begin next_res = o_acc; wr_mem = 1'b1; end
                OP_MOVAX: begin next_res = imm;   wr_acc = 1'b1; end
                // [RULE_06] carry and borrow flags
                OP_ADDM, OP_ADDX, OP_ADCM, OP_SUBM, OP_SUBX, OP_SBCM: begin
                    // [RULE_12] four flags updated
                    {next_ov, next_ac, next_c, next_res} = as;
                    next_z = (as[7:0] == 8'h00);
                    wr_acc = 1'b1;
                end
                // [RULE_12] adjust touches carry only
                OP_DADJ: begin
                    next_res = dadj[7:0];
                    next_c   = dhi;
                    wr_mem   = 1'b1;
                end
                // [RULE_11] accumulator is one operand, except for the complements CPL and CPLA
                OP_ANDM: begin next_res = o_acc & opnd; wr_acc = 1'b1; end
                OP_ORM:  begin next_res = o_acc | opnd; wr_acc = 1'b1; end
                OP_XORM: begin next_res = o_acc ^ opnd; wr_acc = 1'b1; end
                OP_ANDX: begin next_res = o_acc & imm;  wr_acc = 1'b1; end
                OP_ORX:  begin next_res = o_acc | imm;  wr_acc = 1'b1; end
                OP_XORX: begin next_res = o_acc ^ imm;  wr_acc = 1'b1; end
                OP_CPL:  begin next_res = ~opnd; wr_mem = 1'b1; end
                OP_CPLA: begin next_res = ~opnd; wr_acc = 1'b1; end
                // [RULE_07] step by exactly one
                OP_INC:  begin next_res = opnd + 8'h01; wr_mem = 1'b1; end
                OP_INCREMENT_TO_ACCUMULATOR: begin next_res = opnd + 8'h01; wr_acc = 1'b1; end
                OP_DEC:  begin next_res = opnd - 8'h01; wr_mem = 1'b1; end
                OP_DECREMENT_TO_ACCUMULATOR: begin next_res = opnd - 8'h01; wr_acc = 1'b1; end
                // [RULE_09] rotate one bit
                OP_RR: begin next_res = {opnd[0], opnd[7:1]}; wr_mem = 1'b1; end
                OP_RL: begin next_res = {opnd[6:0], opnd[7]}; wr_mem = 1'b1; end
                OP_RRC: begin
                    next_res = {o_carry, opnd[7:1]};
                    next_c   = opnd[0];
                    wr_mem   = 1'b1;
                end
                OP_RLC: begin
                    next_res = {opnd[6:0], o_carry};
                    next_c   = opnd[7];
                    wr_mem   = 1'b1;
                end
                // [RULE_05] skip when operand is zero
                OP_SZ: skip = (opnd == 8'h00);
                OP_RET, OP_RETURN_FROM_INTERRUPT: begin
                    jump   = 1'b1;
                    pop    = 1'b1;
                    set_ie = (op == OP_RETURN_FROM_INTERRUPT);
                    target = stk[sp - 3'h1];
                end
                OP_TABRD: table_rd = 1'b1;
                OP_CLRM:  begin next_res = 8'h00; wr_mem = 1'b1; end
            endcase
            // [RULE_08] zero from logic and step results
            if (op inside {OP_ANDM, OP_ORM, OP_XORM, OP_ANDX, OP_ORX,
                    OP_XORX, OP_CPL, OP_CPLA, OP_INC, OP_INCREMENT_TO_ACCUMULATOR, OP_DEC,
                    OP_DECREMENT_TO_ACCUMULATOR, OP_CLRM})
                next_z = (next_res == 8'h00);
            // [RULE_04] low program counter write is a jump
            if (wr_mem && (maddr == DM_PCL)) begin
                jump   = 1'b1;
                target = {ir_addr[ADDR_W-1:8], next_res};
            end
        end
    end

    // [RULE_01] four clocks per instruction cycle
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            phase    <= PH_FIRST;
            o_icycle <= 1'b0;
        end else begin
            phase    <= phase + 2'h1;
            o_icycle <= (phase == PH_LAST);
        end
    end

    // [RULE_13] flush and refetch on flow change
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            st         <= ST_FLUSH;
            ir         <= '0;
            ir_addr    <= RESET_ADDR;
            pc_save    <= RESET_ADDR;
            tab_dst    <= '0;
            o_pm_addr  <= RESET_ADDR;
            o_executed <= 1'b0;
        end else begin
            o_executed <= ex;
            if (phase == PH_LAST) begin
                unique case (st)
                    ST_RUN: begin
                        if (jump) begin
                            o_pm_addr <= target;
                            st        <= ST_FLUSH;
                        end else if (skip) begin
                            // prefetched word is the skipped one
                            o_pm_addr <= o_pm_addr + 12'h001;
                            st        <= ST_FLUSH;
                        end else begin
                            // [RULE_02] single cycle, keep prefetch
                            ir        <= i_instr;
                            ir_addr   <= o_pm_addr;
                            o_pm_addr <= o_pm_addr + 12'h001;
                            if (table_rd) begin
                                // [RULE_03] second cycle reads table word
                                pc_save   <= o_pm_addr + 12'h001;
                                tab_dst   <= maddr;
                                o_pm_addr <= {o_pm_addr[ADDR_W-1:8],
                                              dm[DM_TBLP]};
                                st        <= ST_TABLE;
                            end
                        end
                    end
                    ST_FLUSH: begin
                        ir        <= i_instr;
                        ir_addr   <= o_pm_addr;
                        o_pm_addr <= o_pm_addr + 12'h001;
                        st        <= ST_RUN;
                    end
                    ST_TABLE: begin
                        o_pm_addr <= pc_save;
                        st        <= ST_RUN;
                    end
                    default: st <= ST_FLUSH;
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_acc        <= 8'h00;
            o_zero       <= 1'b0;
            o_carry      <= 1'b0;
            o_aux_carry  <= 1'b0;
            o_overflow   <= 1'b0;
            o_int_en     <= 1'b0;
            o_table_high <= 7'h00;
            sp           <= '0;
        end else if (ex) begin
            if (wr_acc)
                o_acc <= next_res;
            o_zero      <= next_z;
            o_carry     <= next_c;
            o_aux_carry <= next_ac;
            o_overflow  <= next_ov;
            if (set_ie)
                o_int_en <= 1'b1;
            if (push)
                sp <= sp + 3'h1;
            else if (pop)
                sp <= sp - 3'h1;
        end else if ((st == ST_TABLE) && (phase == PH_LAST)) begin
            o_table_high <= i_instr[WORD_W-1:8];
        end
    end

    // data memory and stack carry no reset; contents are software's
    always_ff @(posedge i_mclk) begin
        if (ex && wr_mem && (maddr != DM_PCL))
            dm[maddr] <= next_res;
        else if ((st == ST_TABLE) && (phase == PH_LAST))
            dm[tab_dst] <= i_instr[7:0];
        if (ex && push)
            stk[sp] <= o_pm_addr;
    end

    property p_icycle_period;
        @(posedge i_mclk) disable iff (i_rst)
        o_icycle |=> !o_icycle [*3] ##1 o_icycle;
    endproperty
    a_icycle_period: assert property (p_icycle_period) // [RULE_01]
        else $error("instruction cycle not four clocks");

    property p_single;
        @(posedge i_mclk) disable iff (i_rst)
        ex && !jump && !skip && !table_rd |=> st == ST_RUN;
    endproperty
    a_single: assert property (p_single) // [RULE_02]
        else $error("plain instruction took extra cycle");

    property p_branch_two;
        @(posedge i_mclk) disable iff (i_rst)
        ex && is_br |=> st == ST_FLUSH ##4 st == ST_RUN;
    endproperty
    a_branch_two: assert property (p_branch_two) // [RULE_03]
        else $error("branch did not take two cycles");

    property p_pcl_jump;
        @(posedge i_mclk) disable iff (i_rst)
        ex && !is_br && wr_mem && maddr == DM_PCL
        |=> st == ST_FLUSH && o_pm_addr[7:0] == $past(next_res);
    endproperty
    a_pcl_jump: assert property (p_pcl_jump) // [RULE_04]
        else $error("low counter write did not jump");

    property p_skip;
        @(posedge i_mclk) disable iff (i_rst)
        ex && !is_br && op == OP_SZ
        |=> (st == ST_FLUSH) == ($past(opnd) == 8'h00);
    endproperty
    a_skip: assert property (p_skip) // [RULE_05]
        else $error("skip timing wrong");

    property p_add_carry;
        @(posedge i_mclk) disable iff (i_rst)
        ex && !is_br && op == OP_ADDX
        |=> o_carry == (({1'b0, $past(o_acc)} + {1'b0, $past(imm)}) > 9'h0FF);
    endproperty
    a_add_carry: assert property (p_add_carry) // [RULE_06]
        else $error("add carry wrong");

    property p_increment_to_accumulator;
        @(posedge i_mclk) disable iff (i_rst)
        ex && !is_br && op == OP_INCREMENT_TO_ACCUMULATOR |=> o_acc == $past(opnd) + 8'h01;
    endproperty
    a_increment_to_accumulator: assert property (p_increment_to_accumulator) // [RULE_07]
        else $error("increment not by one");

    property p_logic_zero;
        @(posedge i_mclk) disable iff (i_rst)
        ex && !is_br && op inside {OP_ANDM, OP_ORX, OP_XORM, OP_CPLA}
        |=> o_zero == (o_acc == 8'h00);
    endproperty
    a_logic_zero: assert property (p_logic_zero) // [RULE_08]
        else $error("zero flag wrong after logic op");

    property p_rrc;
        @(posedge i_mclk) disable iff (i_rst)
        ex && !is_br && op == OP_RRC |=> o_carry == $past(opnd[0]);
    endproperty
    a_rrc: assert property (p_rrc) // [RULE_09]
        else $error("rotate did not pass bit to carry");

    property p_flush_dummy;
        @(posedge i_mclk) disable iff (i_rst)
        st == ST_FLUSH && phase == PH_LAST |=> !o_executed;
    endproperty
    a_flush_dummy: assert property (p_flush_dummy) // [RULE_13]
        else $error("dummy fetch cycle executed");
endmodule : ict_core
`default_nettype wire

// *** rtl/ict_pkg.sv ***
// constants and types for the instruction cycle timing core
`default_nettype none
package ict_pkg;
    localparam int          ADDR_W      = 12;
    localparam int          WORD_W      = 15;
    localparam int          DM_AW       = 6;
    localparam int          DM_DEPTH    = 64;
    localparam int          STK_DEPTH   = 8;
    localparam int          SP_W        = 3;
    localparam logic [1:0]  PH_FIRST    = 2'h0;
    localparam logic [1:0]  PH_LAST     = 2'h3;
    localparam logic [DM_AW-1:0] DM_PCL  = 6'h02;
    localparam logic [DM_AW-1:0] DM_TBLP = 6'h03;
    localparam int          BR_HI       = 14;
    localparam int          BR_LO       = 13;
    localparam logic [1:0]  BR_PFX      = 2'h3;
    localparam int          BR_CALL_BIT = 12;
    localparam int          OPC_HI      = 12;
    localparam int          OPC_LO      = 8;
    localparam logic [3:0]  BCD_NINE    = 4'h9;
    localparam logic [8:0]  BCD_ADJ_LO  = 9'h006;
    localparam logic [8:0]  BCD_ADJ_HI  = 9'h060;
    localparam logic [ADDR_W-1:0] RESET_ADDR = 12'h000;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_FLUSH = 2'b01,
        ST_TABLE = 2'b10
    } ict_state_t;

    typedef enum logic [4:0] {
        OP_NOP   = 5'b00000, OP_MOVAM = 5'b00001, OP_MOVMA = 5'b00010,
        OP_MOVAX = 5'b00011, OP_ADDM  = 5'b00100, OP_ADDX  = 5'b00101,
        OP_ADCM  = 5'b00110, OP_SUBM  = 5'b00111, OP_SUBX  = 5'b01000,
        OP_SBCM  = 5'b01001, OP_DADJ  = 5'b01010, OP_ANDM  = 5'b01011,
        OP_ORM   = 5'b01100, OP_XORM  = 5'b01101, OP_ANDX  = 5'b01110,
        OP_ORX   = 5'b01111, OP_XORX  = 5'b10000, OP_CPL   = 5'b10001,
        OP_CPLA  = 5'b10010, OP_INC   = 5'b10011, OP_INCREMENT_TO_ACCUMULATOR  = 5'b10100,
        OP_DEC   = 5'b10101, OP_DECREMENT_TO_ACCUMULATOR  = 5'b10110, OP_RR    = 5'b10111,
        OP_RL    = 5'b11000, OP_RRC   = 5'b11001, OP_RLC   = 5'b11010,
        OP_SZ    = 5'b11011, OP_RET   = 5'b11100, OP_RETURN_FROM_INTERRUPT  = 5'b11101,
        OP_TABRD = 5'b11110, OP_CLRM  = 5'b11111
    } ict_op_t;
endpackage : ict_pkg
`default_nettype wire

// *** tb/ict_pm_model.sv ***
// program memory model with a slow, scrambled answer
`default_nettype none
module ict_pm_model #(
    parameter int LAT = 2
) (
    input  wire logic [0:0]                 i_mclk,
    input  wire logic [ict_pkg::ADDR_W-1:0] i_pm_addr,
    output var  logic [ict_pkg::WORD_W-1:0] o_word
);
    timeunit 1ns;
    timeprecision 1ps;
    import ict_pkg::*;
    logic [WORD_W-1:0] mem [1<<ADDR_W];
    logic [ADDR_W-1:0] last = '1;
    int                cnt  = 0;

    initial o_word = '0;

    // stale word is inverted so an early sample never matches by luck
    always @(posedge i_mclk) begin
        if (i_pm_addr != last) begin
            last   <= i_pm_addr;
            cnt    <= 0;
            o_word <= ~o_word;
        end else if (cnt < LAT - 1) begin
            cnt <= cnt + 1;
        end else begin
            o_word <= mem[i_pm_addr];
        end
    end
endmodule : ict_pm_model
`default_nettype wire

// *** tb/test_instruction_cycle_timing.sv ***
// self-checking bench for the instruction cycle timing core
`default_nettype none
module test_instruction_cycle_timing;
    timeunit 1ns;
    timeprecision 1ps;
    import ict_pkg::*;
    logic              i_mclk      = 1'b0;
    logic              i_rst       = 1'b1;
    logic [WORD_W-1:0] word;
    logic [ADDR_W-1:0] pm_addr;
    logic [7:0]        acc;
    logic [6:0]        thigh;
    logic              zero;
    logic              carry;
    logic              aux;
    logic              ovf;
    logic              int_en;
    logic              icycle;
    logic              executed;
    int                miscompares = 0;
    int                n_compared  = 0;
    logic [ADDR_W-1:0] s_addr [32];
    logic [7:0]        s_acc  [32];
    logic [1:0]        s_zc   [32];
    logic [1:0]        s_v    [32];
    logic [31:0]       s_ex;
    logic [ADDR_W-1:0] e_addr [$];

    always #2.5 i_mclk = ~i_mclk;

    ict_core ict_core_i (
        .i_mclk       (i_mclk),
        .i_rst        (i_rst),
        .i_instr      (word),
        .o_pm_addr    (pm_addr),
        .o_acc        (acc),
        .o_zero       (zero),
        .o_carry      (carry),
        .o_aux_carry  (aux),
        .o_overflow   (ovf),
        .o_int_en     (int_en),
        .o_table_high (thigh),
        .o_icycle     (icycle),
        .o_executed   (executed)
    );

    // two-clock answer uses most of the fetch window
    ict_pm_model #(.LAT(2)) ict_pm_model_i (
        .i_mclk    (i_mclk),
        .i_pm_addr (pm_addr),
        .o_word    (word)
    );

    function automatic logic [WORD_W-1:0] op(ict_op_t o, logic [7:0] v);
        return {2'h0, o, v};
    endfunction : op

    function automatic logic [WORD_W-1:0] br(logic c, logic [11:0] a);
        return {BR_PFX, c, a};
    endfunction : br

    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic results();
        if (miscompares == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic put(logic [11:0] a, logic [WORD_W-1:0] w);
        ict_pm_model_i.mem[a] = w;
    endtask : put

    task automatic clear();
        for (int a = 0; a < (1 << ADDR_W); a++) begin
            ict_pm_model_i.mem[a] = '0;
        end
    endtask : clear

    // resets, samples the dummy fetch, then each instruction-cycle pulse
    task automatic run(int n);
        int gap;
        s_ex = '0;
        @(negedge i_mclk);
        i_rst = 1'b1;
        repeat (3) @(negedge i_mclk);
        i_rst = 1'b0;
        for (int k = 0; k < n; k++) begin
            // no pulse marks the dummy fetch right after reset
            if (k > 0) begin
                gap = 0;
                do begin
                    @(negedge i_mclk);
                    gap++;
                end while (icycle !== 1'b1 && gap < 9);
                if (icycle !== 1'b1) begin
                    miscompares++;
                    results();
                end
                chk("icycle_gap", 16'(gap), 16'h4);
            end
            s_addr[k] = pm_addr;
            s_acc[k]  = acc;
            s_zc[k]   = {zero, carry};
            s_v[k]    = {aux, ovf};
            s_ex[k]   = executed;
        end
    endtask : run

    task automatic seq(string what, logic [31:0] ex);
        for (int k = 0; k < e_addr.size(); k++) begin
            chk(what, 16'(s_addr[k]), 16'(e_addr[k]));
        end
        chk(what, s_ex[15:0], ex[15:0]);
    endtask : seq

    task automatic t_alu();
        logic [WORD_W-1:0] p   [24];
        logic [7:0]        ea  [24];
        logic [1:0]        ezc [24];
        p = '{op(OP_MOVAX, 8'hF0), op(OP_ADDX, 8'h20), op(OP_SUBX, 8'h20),
              op(OP_ADDX, 8'h10), op(OP_MOVAX, 8'h7F), op(OP_ADDX, 8'h01),
              op(OP_MOVMA, 8'h20), op(OP_XORX, 8'h80), op(OP_ORX, 8'h01),
              op(OP_ANDX, 8'h02), op(OP_INCREMENT_TO_ACCUMULATOR, 8'h20), op(OP_DECREMENT_TO_ACCUMULATOR, 8'h20),
              op(OP_CPLA, 8'h20), op(OP_RLC, 8'h20), op(OP_MOVAM, 8'h20),
              op(OP_RRC, 8'h20), op(OP_MOVAM, 8'h20), op(OP_RL, 8'h20),
              op(OP_MOVAM, 8'h20), op(OP_RR, 8'h20), op(OP_MOVAM, 8'h20),
              op(OP_MOVAX, 8'h9A), op(OP_DADJ, 8'h21), op(OP_MOVAM, 8'h21)};
        ea = '{8'hF0, 8'h10, 8'hF0, 8'h00, 8'h7F, 8'h80, 8'h80, 8'h00,
               8'h01, 8'h00, 8'h81, 8'h7F, 8'h7F, 8'h7F, 8'h00, 8'h00,
               8'h80, 8'h80, 8'h01, 8'h01, 8'h80, 8'h9A, 8'h9A, 8'h00};
        ezc = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h3, 2'h0, 2'h0, 2'h2,
                2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0,
                2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
        clear();
        for (int k = 0; k < 24; k++) begin
            put(12'(k), p[k]);
        end
        run(26);
        chk("reset_acc", 16'(s_acc[0]), 16'h0);
        for (int k = 0; k < 24; k++) begin
            chk("alu_acc", 16'(s_acc[k+2]), 16'(ea[k]));
            chk("alu_zc", 16'(s_zc[k+2]), 16'(ezc[k]));
        end
        chk("sub_aux_ovf", 16'(s_v[4]), 16'h0);
        chk("add_aux_ovf", 16'(s_v[7]), 16'h3);
    endtask : t_alu

    // memory operands: carry chains, logic and in-place steps
    task automatic t_mem();
        logic [WORD_W-1:0] p   [19];
        logic [7:0]        ea  [19];
        logic [1:0]        ezc [19];
        p = '{op(OP_MOVAX, 8'h0F), op(OP_MOVMA, 8'h30), op(OP_MOVAX, 8'hF8),
              op(OP_ADDM, 8'h30), op(OP_ADCM, 8'h30), op(OP_SUBM, 8'h30),
              op(OP_SBCM, 8'h30), op(OP_SBCM, 8'h30), op(OP_ANDM, 8'h30),
              op(OP_XORM, 8'h30), op(OP_ORM, 8'h30), op(OP_XORM, 8'h30),
              op(OP_INC, 8'h30), op(OP_MOVAM, 8'h30), op(OP_DEC, 8'h30),
              op(OP_CPL, 8'h30), op(OP_MOVAM, 8'h30), op(OP_CLRM, 8'h30),
              op(OP_MOVAM, 8'h30)};
        ea = '{8'h0F, 8'h0F, 8'hF8, 8'h07, 8'h17, 8'h08, 8'hF9, 8'hE9,
               8'h09, 8'h06, 8'h0F, 8'h00, 8'h00, 8'h10, 8'h10, 8'h10,
               8'hF0, 8'hF0, 8'h00};
        ezc = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h0,
                2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0,
                2'h0, 2'h2, 2'h2};
        clear();
        for (int k = 0; k < 19; k++) begin
            put(12'(k), p[k]);
        end
        run(21);
        for (int k = 0; k < 19; k++) begin
            chk("mem_acc", 16'(s_acc[k+2]), 16'(ea[k]));
            chk("mem_zc", 16'(s_zc[k+2]), 16'(ezc[k]));
        end
        chk("addm_aux_ovf", 16'(s_v[5]), 16'h2);
    endtask : t_mem

    task automatic t_flow();
        clear();
        put(12'h000, br(1'b0, 12'h020));
        put(12'h020, br(1'b1, 12'h030));
        put(12'h021, br(1'b1, 12'h040));
        put(12'h030, op(OP_RET, 8'h00));
        put(12'h040, op(OP_RETURN_FROM_INTERRUPT, 8'h00));
        run(12);
        e_addr = '{12'h000, 12'h001, 12'h020, 12'h021, 12'h030, 12'h031,
                   12'h021, 12'h022, 12'h040, 12'h041, 12'h022, 12'h023};
        seq("flow", 32'h554);
        chk("int_en", 16'(int_en), 16'h1);
    endtask : t_flow

    // writing the low address byte must drop the prefetched word
    task automatic t_pcl();
        clear();
        put(12'h000, op(OP_MOVAX, 8'h60));
        put(12'h001, op(OP_MOVMA, 8'(DM_PCL)));
        put(12'h002, op(OP_MOVAX, 8'hFF));
        run(6);
        e_addr = '{12'h000, 12'h001, 12'h002, 12'h060, 12'h061, 12'h062};
        seq("pc_low_jump", 32'h2C);
        chk("pc_low_acc", 16'(acc), 16'h60);
    endtask : t_pcl

    task automatic t_table();
        clear();
        put(12'h000, op(OP_MOVAX, 8'h50));
        put(12'h001, op(OP_MOVMA, 8'(DM_TBLP)));
        put(12'h002, op(OP_TABRD, 8'h11));
        put(12'h003, op(OP_MOVAM, 8'h11));
        put(12'h050, 15'h2ABC);
        run(10);
        chk("table_low", 16'(acc), 16'hBC);
        chk("table_high", 16'(thigh), 16'h2A);
    endtask : t_table

    task automatic t_skip(logic [7:0] v, logic [7:0] eacc, logic [31:0] ex);
        clear();
        put(12'h000, op(OP_MOVAX, v));
        put(12'h001, op(OP_MOVMA, 8'h12));
        put(12'h002, op(OP_SZ, 8'h12));
        put(12'h003, op(OP_MOVAX, 8'h11));
        put(12'h004, op(OP_ADDX, 8'h01));
        run(7);
        e_addr = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004, 12'h005,
                   12'h006};
        seq("skip", ex);
        chk("skip_acc", 16'(s_acc[6]), 16'(eacc));
    endtask : t_skip

    initial begin
        t_alu();
        t_mem();
        t_flow();
        t_pcl();
        t_table();
        t_skip(8'h00, 8'h01, 32'h5C);
        t_skip(8'h07, 8'h12, 32'h7C);
        results();
    end
endmodule : test_instruction_cycle_timing
`default_nettype wire
